/* verilog/crc_config_regs.sv */
// Charge regulation configuration bank with its I2C target and watchdog.
// Assumes scl and sda arrive already synchronous to clk, and an external
// pull-up makes the open-drain sda wire.

`default_nettype none

module crc_config_regs
#(
	parameter logic [6:0]  DEV_ADDR         = crc_pkg::CRC_DEV_ADDR_DEFAULT,
	parameter logic [35:0] WDOG_BASE_CYCLES = crc_pkg::CRC_WDOG_BASE_CYCLES
)
(
	input  wire logic       clk,
	input  wire logic       rstn,
	input  wire logic       scl_in,
	input  wire logic       sda_in,
	output logic            sda_out,
	output logic            sda_oe_n,
	output logic [5:0]      charge_voltage_code,
	output logic            precharge_exit_threshold_sel,
	output logic            recharge_offset_sel,
	output logic            term_enable,
	output logic            term_early_ind,
	output logic [1:0]      watchdog_period_sel,
	output logic            safety_timer_enable,
	output logic [1:0]      fast_charge_time_limit,
	output logic            cold_current_ratio_sel,
	output logic [2:0]      ir_comp_resistance,
	output logic [2:0]      ir_comp_clamp,
	output logic [1:0]      die_temp_limit,
	output logic            watchdog_expired
);
	import crc_pkg::*;

	// ------------------------------------------------------------------
	// Declarations.
	// ------------------------------------------------------------------
	crc_state_t  state_ff;
	crc_state_t  ack_next_ff;
	logic        scl_q_ff;
	logic        sda_q_ff;
	logic [2:0]  bit_cnt_ff;
	logic [7:0]  rx_ff;
	logic [7:0]  tx_ff;
	logic [7:0]  index_ff;
	logic        ack_drv_ff;
	logic        sda_oe_n_ff;
	logic        sda_out_ff;
	logic [7:0]  chg_volt_ff;
	logic [7:0]  term_tmr_ff;
	logic [7:0]  comp_therm_ff;
	logic        wdog_kick_ff;

	logic        scl_rise;
	logic        scl_fall;
	logic        bus_start;
	logic        bus_stop;
	logic [7:0]  rx_byte;
	logic        rx_state;
	logic        byte_done;
	logic        wr_en;
	logic [7:0]  wr_idx;
	logic [7:0]  wr_data;
	logic [7:0]  rd_byte;
	logic [7:0]  rd_next;

	crc_wdog_if wd_if ();

	// ------------------------------------------------------------------
	// Read decode.
	// ------------------------------------------------------------------

	// Unmapped indices read as zero; the kick bit reads back while pending.
	function automatic logic [7:0] read_mux(input logic [7:0] idx);
		logic [7:0] val;
		val = 8'h00;
		case (idx)
			CRC_IDX_PWR_CFG:    val[CRC_WDOG_KICK_BIT] = wdog_kick_ff;
			CRC_IDX_CHG_VOLT:   val = chg_volt_ff;       // RQ16
			CRC_IDX_TERM_TMR:   val = term_tmr_ff;
			CRC_IDX_COMP_THERM: val = comp_therm_ff;
			default:            val = 8'h00;
		endcase
		return val;
	endfunction

	// A process, not an assign: a write must show even while the index holds still.
	always_comb
	begin
		rd_byte = read_mux(index_ff);
		rd_next = read_mux(index_ff + 8'h01);
	end

	// ------------------------------------------------------------------
	// Bus line events.
	// ------------------------------------------------------------------

	// Inputs are already synchronous, so one stage of history finds edges.
	always_ff @(posedge clk)
	begin
		if (!rstn)
		begin
			scl_q_ff <= 1'b1;
			sda_q_ff <= 1'b1;
		end
		else
		begin
			scl_q_ff <= scl_in;
			sda_q_ff <= sda_in;
		end
	end

	// Start and stop are sda edges while scl stays high.
	assign scl_rise  = scl_in && !scl_q_ff;
	assign scl_fall  = !scl_in && scl_q_ff;
	assign bus_start = scl_in && scl_q_ff && sda_q_ff && !sda_in;
	assign bus_stop  = scl_in && scl_q_ff && !sda_q_ff && sda_in;
	assign rx_byte   = {rx_ff[6:0], sda_in};
	assign rx_state  = state_ff == ST_ADDR || state_ff == ST_INDEX || state_ff == ST_WDATA;
	assign byte_done = rx_state && scl_rise && bit_cnt_ff == 3'h7;
	assign wr_en     = byte_done && state_ff == ST_WDATA;
	assign wr_idx    = index_ff;
	assign wr_data   = rx_byte;

	// ------------------------------------------------------------------
	// Bus target sequence.
	// ------------------------------------------------------------------

	// A start wins over everything but reset, so a stuck transfer is always recoverable.
	// The pin is only ever pulled low: data is shifted out on scl falling
	// edges and sampled by the controller on the rising ones.
	always_ff @(posedge clk)
	begin
		if (!rstn)
		begin
			state_ff    <= ST_IDLE;
			ack_next_ff <= ST_IDLE;
			bit_cnt_ff  <= 3'h0;
			rx_ff       <= 8'h00;
			tx_ff       <= 8'h00;
			index_ff    <= 8'h00;
			ack_drv_ff  <= 1'b0;
			sda_oe_n_ff <= 1'b1;
		end
		else if (bus_start)
		begin
			state_ff    <= ST_ADDR;
			bit_cnt_ff  <= 3'h0;
			ack_drv_ff  <= 1'b0;
			sda_oe_n_ff <= 1'b1;
		end
		else if (bus_stop)
		begin
			state_ff    <= ST_IDLE;
			sda_oe_n_ff <= 1'b1;
		end
		else
		begin
			case (state_ff)
				ST_IDLE:
					sda_oe_n_ff <= 1'b1;
				ST_ADDR, ST_INDEX, ST_WDATA:
					if (scl_rise)
					begin
						rx_ff      <= rx_byte;
						bit_cnt_ff <= bit_cnt_ff + 3'h1;
						if (byte_done)
						begin
							state_ff <= ST_ACK;
							if (state_ff == ST_ADDR)
							begin
								// A foreign address is ignored until the next start.
								if (rx_byte[7:1] != DEV_ADDR)
									state_ff <= ST_IDLE;
								ack_next_ff <= rx_byte[0] ? ST_RDATA : ST_INDEX;
							end
							else if (state_ff == ST_INDEX)
							begin
								index_ff    <= rx_byte;          // RQ17
								ack_next_ff <= ST_WDATA;
							end
							else
							begin
								index_ff    <= index_ff + 8'h01;
								ack_next_ff <= ST_WDATA;
							end
						end
					end
				ST_ACK:
					if (scl_fall)
					begin
						if (!ack_drv_ff)
						begin
							sda_oe_n_ff <= 1'b0;
							ack_drv_ff  <= 1'b1;
						end
						else
						begin
							ack_drv_ff <= 1'b0;
							state_ff   <= ack_next_ff;
							bit_cnt_ff <= 3'h0;
							if (ack_next_ff == ST_RDATA)
							begin
								tx_ff       <= rd_byte;
								sda_oe_n_ff <= rd_byte[7];
							end
							else
								sda_oe_n_ff <= 1'b1;
						end
					end
				ST_RDATA:
					if (scl_fall)
					begin
						tx_ff       <= {tx_ff[6:0], 1'b0};
						sda_oe_n_ff <= tx_ff[6];
					end
					else if (scl_rise)
					begin
						bit_cnt_ff <= bit_cnt_ff + 3'h1;
						if (bit_cnt_ff == 3'h7)
						begin
							state_ff   <= ST_RACK;
							ack_drv_ff <= 1'b0;
						end
					end
				ST_RACK:
					// Here ack_drv_ff marks that the controller acknowledged.
					if (scl_fall && !ack_drv_ff)
						sda_oe_n_ff <= 1'b1;
					else if (scl_rise)
					begin
						if (sda_in)
							state_ff <= ST_IDLE;
						else
							ack_drv_ff <= 1'b1;
					end
					else if (scl_fall)
					begin
						ack_drv_ff  <= 1'b0;
						index_ff    <= index_ff + 8'h01;
						tx_ff       <= rd_next;
						sda_oe_n_ff <= rd_next[7];
						bit_cnt_ff  <= 3'h0;
						state_ff    <= ST_RDATA;
					end
				default:
					state_ff <= ST_IDLE;
			endcase
		end
	end

	// The data line is only ever pulled low, so its level is fixed.
	always_ff @(posedge clk)
	begin
		if (!rstn)
			sda_out_ff <= 1'b0;
		else
			sda_out_ff <= 1'b0;
	end

	// ------------------------------------------------------------------
	// Configuration registers.
	// ------------------------------------------------------------------

	// Whole-byte writes; reserved bits do not exist in these three registers.
	always_ff @(posedge clk)
	begin
		if (!rstn)
		begin
			chg_volt_ff   <= CRC_RST_CHG_VOLT;      // RQ14
			term_tmr_ff   <= CRC_RST_TERM_TMR;
			comp_therm_ff <= CRC_RST_COMP_THERM;
		end
		else if (wr_en)
		begin
			case (wr_idx)
				CRC_IDX_CHG_VOLT:   chg_volt_ff   <= wr_data;   // RQ16
				CRC_IDX_TERM_TMR:   term_tmr_ff   <= wr_data;
				CRC_IDX_COMP_THERM: comp_therm_ff <= wr_data;
				default:            chg_volt_ff   <= chg_volt_ff;
			endcase
		end
	end

	// A new request that lands on the clearing cycle is kept, not lost.
	always_ff @(posedge clk)
	begin
		if (!rstn)
			wdog_kick_ff <= 1'b0;
		else if (wr_en && wr_idx == CRC_IDX_PWR_CFG && wr_data[CRC_WDOG_KICK_BIT])
			wdog_kick_ff <= 1'b1;                  // RQ15
		else if (wd_if.restarted)
			wdog_kick_ff <= 1'b0;
	end

	// ------------------------------------------------------------------
	// Watchdog.
	// ------------------------------------------------------------------
	assign wd_if.kick       = wdog_kick_ff;
	assign wd_if.period_sel = term_tmr_ff[CRC_WDOG_MSB:CRC_WDOG_LSB];   // RQ7

	crc_wdog #(
		.BASE_CYCLES (WDOG_BASE_CYCLES)
	) u_wdog (
		.clk  (clk),
		.rstn (rstn),
		.wd   (wd_if.timer)
	);

	// ------------------------------------------------------------------
	// Field outputs.
	// ------------------------------------------------------------------
	assign sda_out                      = sda_out_ff;
	assign sda_oe_n                     = sda_oe_n_ff;
	assign charge_voltage_code          = chg_volt_ff[CRC_CV_MSB:CRC_CV_LSB];      // RQ1
	assign precharge_exit_threshold_sel = chg_volt_ff[CRC_PRECHG_BIT];             // RQ3
	assign recharge_offset_sel          = chg_volt_ff[CRC_RECHG_BIT];              // RQ4
	assign term_enable                  = term_tmr_ff[CRC_TERM_EN_BIT];            // RQ5
	assign term_early_ind               = term_tmr_ff[CRC_TERM_IND_BIT];           // RQ6
	assign watchdog_period_sel          = term_tmr_ff[CRC_WDOG_MSB:CRC_WDOG_LSB];
	assign safety_timer_enable          = term_tmr_ff[CRC_TMR_EN_BIT];             // RQ8
	assign fast_charge_time_limit       = term_tmr_ff[CRC_CHG_TMR_MSB:CRC_CHG_TMR_LSB]; // RQ9
	assign cold_current_ratio_sel       = term_tmr_ff[CRC_COLD_BIT];               // RQ10
	assign ir_comp_resistance           = comp_therm_ff[CRC_COMP_R_MSB:CRC_COMP_R_LSB]; // RQ11
	assign ir_comp_clamp                = comp_therm_ff[CRC_CLAMP_MSB:CRC_CLAMP_LSB];   // RQ12
	assign die_temp_limit               = comp_therm_ff[CRC_TLIM_MSB:CRC_TLIM_LSB];     // RQ13
	assign watchdog_expired             = wd_if.expired;

	// ------------------------------------------------------------------
	// Checks.
	// ------------------------------------------------------------------
	property p_rst_vals;
		@(posedge clk) disable iff (!rstn)
		$rose(rstn) |-> chg_volt_ff == CRC_RST_CHG_VOLT && term_tmr_ff == CRC_RST_TERM_TMR
			&& comp_therm_ff == CRC_RST_COMP_THERM;
	endproperty
	a_rst_vals: assert property (p_rst_vals) else $error("Reset values wrong."); // RQ14

	property p_cv_rst;
		@(posedge clk) disable iff (!rstn)
		$rose(rstn) |-> charge_voltage_code == CRC_RST_CV_CODE;
	endproperty
	a_cv_rst: assert property (p_cv_rst) else $error("Voltage code reset wrong."); // RQ2

	property p_sel_rst;
		@(posedge clk) disable iff (!rstn)
		$rose(rstn) |-> precharge_exit_threshold_sel && !recharge_offset_sel && term_enable
			&& safety_timer_enable && die_temp_limit == 2'h3;
	endproperty
	a_sel_rst: assert property (p_sel_rst) else $error("Select bits reset wrong."); // RQ3

	property p_wr_volt;
		@(posedge clk) disable iff (!rstn)
		wr_en && wr_idx == CRC_IDX_CHG_VOLT |=>
			{charge_voltage_code, precharge_exit_threshold_sel, recharge_offset_sel}
			== $past(wr_data);
	endproperty
	a_wr_volt: assert property (p_wr_volt) else $error("Voltage write lost."); // RQ1

	property p_wr_timer;
		@(posedge clk) disable iff (!rstn)
		wr_en && wr_idx == CRC_IDX_TERM_TMR |=> {term_enable, term_early_ind,
			watchdog_period_sel, safety_timer_enable, fast_charge_time_limit,
			cold_current_ratio_sel} == $past(wr_data);
	endproperty
	a_wr_timer: assert property (p_wr_timer) else $error("Timer write lost."); // RQ9

	property p_wr_comp;
		@(posedge clk) disable iff (!rstn)
		wr_en && wr_idx == CRC_IDX_COMP_THERM |=>
			{ir_comp_resistance, ir_comp_clamp, die_temp_limit} == $past(wr_data);
	endproperty
	a_wr_comp: assert property (p_wr_comp) else $error("Compensation write lost."); // RQ11

	property p_keep;
		@(posedge clk) disable iff (!rstn)
		!wr_en |=> $stable(chg_volt_ff) && $stable(term_tmr_ff) && $stable(comp_therm_ff);
	endproperty
	a_keep: assert property (p_keep) else $error("Register changed without a write."); // RQ16

	property p_kick_clr;
		@(posedge clk) disable iff (!rstn)
		$rose(wdog_kick_ff) |-> ##[2:3] !wdog_kick_ff;
	endproperty
	a_kick_clr: assert property (p_kick_clr) else $error("Kick bit did not clear."); // RQ15

	property p_ack_low;
		@(posedge clk) disable iff (!rstn)
		state_ff == ST_ACK && ack_drv_ff |-> !sda_oe_n_ff;
	endproperty
	a_ack_low: assert property (p_ack_low) else $error("Acknowledge not driven."); // RQ17

endmodule // crc_config_regs

`default_nettype wire

/* inc/crc_pkg.sv */
// Constants, types and field layout for the charge regulation configuration bank.
// Assumes a single 125 MHz clock with a synchronous active-low reset.
//
// How it works
// (RQ1) The charge voltage target is a 6-bit code in bits 7:2 of the charge-voltage register, 3.504 V plus 16 mV per step, topping out at 4.400 V.
// (RQ2) After reset the charge voltage code is 101100, which means 4.208 V.
// (RQ3) Bit 1 of the charge-voltage register picks the precharge exit level, 0 for 2.8 V and 1 for 3.0 V, and resets to 1.
// (RQ4) Bit 0 of the charge-voltage register picks the recharge offset below regulation, 0 for 100 mV and 1 for 300 mV, and resets to 0.
// (RQ5) Bit 7 of the termination/timer register enables charge termination and resets to 1.
// (RQ6) Bit 6 of the termination/timer register makes the done indication come early below 800 mA when set, and resets to 0.
// (RQ7) Bits 5:4 of the termination/timer register set the watchdog period as off, 40 s, 80 s or 160 s, and reset to 01.
// (RQ8) Bit 3 of the termination/timer register enables the fast-charge safety timer and resets to 1.
// (RQ9) Bits 2:1 of the termination/timer register give a safety limit of 5, 8, 12 or 20 hours and reset to 01.
// (RQ10) Bit 0 of the termination/timer register sets the cold-band current to 50 % when 0 or 20 % when 1, and resets to 0.
// (RQ11) Bits 7:5 of the compensation/thermal register hold the IR compensation resistance in 10 mOhm steps, resetting to 0.
// (RQ12) Bits 4:2 of the compensation/thermal register hold the IR compensation clamp in 16 mV steps up to 112 mV, resetting to 0.
// (RQ13) Bits 1:0 of the compensation/thermal register pick a die limit of 60, 80, 100 or 120 C and reset to 11.
// (RQ14) Reset loads 0xB2, 0x9A and 0x03 into the three registers.
// (RQ15) The host restarts the watchdog with a self-clearing bit in the power-on configuration register, and the device clears it once restarted.
// (RQ16) Every field reads back what the host last wrote, or its reset value.
// (RQ17) The host uses single-byte I2C writes and reads addressed by register index.

`default_nettype none

package crc_pkg;

	// ------------------------------------------------------------------
	// Register indices.
	// ------------------------------------------------------------------
	localparam logic [7:0] CRC_IDX_PWR_CFG    = 8'h01;
	localparam logic [7:0] CRC_IDX_CHG_VOLT   = 8'h04;
	localparam logic [7:0] CRC_IDX_TERM_TMR   = 8'h05;
	localparam logic [7:0] CRC_IDX_COMP_THERM = 8'h06;

	// ------------------------------------------------------------------
	// Reset values.
	// ------------------------------------------------------------------
	localparam logic [7:0] CRC_RST_CHG_VOLT   = 8'hb2;
	localparam logic [7:0] CRC_RST_TERM_TMR   = 8'h9a;
	localparam logic [7:0] CRC_RST_COMP_THERM = 8'h03;
	localparam logic [5:0] CRC_RST_CV_CODE    = 6'h2c;

	// ------------------------------------------------------------------
	// Field positions.
	// ------------------------------------------------------------------
	localparam int CRC_CV_MSB        = 7;
	localparam int CRC_CV_LSB        = 2;
	localparam int CRC_PRECHG_BIT    = 1;
	localparam int CRC_RECHG_BIT     = 0;
	localparam int CRC_TERM_EN_BIT   = 7;
	localparam int CRC_TERM_IND_BIT  = 6;
	localparam int CRC_WDOG_MSB      = 5;
	localparam int CRC_WDOG_LSB      = 4;
	localparam int CRC_TMR_EN_BIT    = 3;
	localparam int CRC_CHG_TMR_MSB   = 2;
	localparam int CRC_CHG_TMR_LSB   = 1;
	localparam int CRC_COLD_BIT      = 0;
	localparam int CRC_COMP_R_MSB    = 7;
	localparam int CRC_COMP_R_LSB    = 5;
	localparam int CRC_CLAMP_MSB     = 4;
	localparam int CRC_CLAMP_LSB     = 2;
	localparam int CRC_TLIM_MSB      = 1;
	localparam int CRC_TLIM_LSB      = 0;
	localparam int CRC_WDOG_KICK_BIT = 6;

	// ------------------------------------------------------------------
	// Timing and bus constants.
	// ------------------------------------------------------------------
	localparam longint unsigned CRC_CLK_HZ      = 64'd125_000_000;
	localparam longint unsigned CRC_WDOG_BASE_S = 64'd40;
	localparam int              CRC_WDOG_CW     = 36;
	localparam logic [35:0]     CRC_WDOG_BASE_CYCLES = 36'(CRC_WDOG_BASE_S * CRC_CLK_HZ);
	localparam logic [1:0]      CRC_WDOG_OFF    = 2'h0;
	// Bus address value is arbitrary.
	localparam logic [6:0]      CRC_DEV_ADDR_DEFAULT = 7'h2a;

	// ------------------------------------------------------------------
	// Bus target states.
	// ------------------------------------------------------------------
	typedef enum logic [2:0] {
		ST_IDLE  = 3'b000,
		ST_ADDR  = 3'b001,
		ST_INDEX = 3'b010,
		ST_WDATA = 3'b011,
		ST_ACK   = 3'b100,
		ST_RDATA = 3'b101,
		ST_RACK  = 3'b110
	} crc_state_t;

endpackage

`default_nettype wire

/* inc/crc_wdog_if.sv */
// Link between the register bank and its watchdog timer.
// Assumes both ends share one clock; no clocking of its own.

`default_nettype none

interface crc_wdog_if;
	logic       kick;
	logic [1:0] period_sel;
	logic       restarted;
	logic       expired;

	modport regs  (output kick, output period_sel, input restarted, input expired);
	modport timer (input kick, input period_sel, output restarted, output expired);
endinterface

`default_nettype wire

/* verilog/crc_wdog.sv */
// Host watchdog timer for the configuration bank.
// Assumes the bank holds the kick level until the restart pulse comes back.

`default_nettype none

module crc_wdog
#(
	parameter logic [35:0] BASE_CYCLES = crc_pkg::CRC_WDOG_BASE_CYCLES
)
(
	input  wire logic     clk,
	input  wire logic     rstn,
	crc_wdog_if.timer     wd
);
	import crc_pkg::*;

	logic [35:0] count_ff;
	logic [35:0] limit;
	logic        restarted_ff;
	logic        expired_ff;

	// ------------------------------------------------------------------
	// Period decode.
	// ------------------------------------------------------------------

	// Longer periods are shifts of the base so only one long constant exists.
	always_comb
	begin
		case (wd.period_sel)
			2'h1:    limit = BASE_CYCLES;            // RQ7
			2'h2:    limit = BASE_CYCLES << 1;
			2'h3:    limit = BASE_CYCLES << 2;
			default: limit = BASE_CYCLES;
		endcase
	end

	// ------------------------------------------------------------------
	// Counter.
	// ------------------------------------------------------------------

	// Expiry is sticky until the host kicks or turns the timer off.
	always_ff @(posedge clk)
	begin
		if (!rstn)
		begin
			count_ff   <= 36'h0_0000_0000;
			expired_ff <= 1'b0;
		end
		else if (wd.kick || wd.period_sel == CRC_WDOG_OFF)
		begin
			count_ff   <= 36'h0_0000_0000;       // RQ15
			expired_ff <= 1'b0;                   // RQ7
		end
		else if (count_ff >= limit - 36'h0_0000_0001)
			expired_ff <= 1'b1;
		else
			count_ff <= count_ff + 36'h0_0000_0001;
	end

	// One pulse per kick, so the bank clears its bit exactly once.
	always_ff @(posedge clk)
	begin
		if (!rstn)
			restarted_ff <= 1'b0;
		else
			restarted_ff <= wd.kick && !restarted_ff;   // RQ15
	end

	assign wd.restarted = restarted_ff;
	assign wd.expired   = expired_ff;

	// ------------------------------------------------------------------
	// Checks.
	// ------------------------------------------------------------------
	property p_wd_off;
		@(posedge clk) disable iff (!rstn)
		wd.period_sel == CRC_WDOG_OFF |=> !expired_ff && count_ff == 36'h0_0000_0000;
	endproperty
	a_wd_off: assert property (p_wd_off) else $error("Watchdog runs while disabled."); // RQ7

	property p_wd_kick;
		@(posedge clk) disable iff (!rstn)
		$rose(wd.kick) |=> restarted_ff && count_ff == 36'h0_0000_0000 ##1 !restarted_ff;
	endproperty
	a_wd_kick: assert property (p_wd_kick) else $error("Kick did not restart the timer."); // RQ15

endmodule // crc_wdog

`default_nettype wire

/* verif/crc_i2c_host.sv */
// I2C controller model standing in for the host processor.
// Assumes the bench resolves the open-drain sda wire with a pull-up.
`default_nettype none
module crc_i2c_host
(
	input  wire logic clk,
	input  wire logic sda,
	output logic      scl,
	output logic      sda_oe_n
);
	timeunit 1ns;
	timeprecision 1ps;
	// ------------------------------------------------------------
	// Bus primitives.
	// ------------------------------------------------------------
	// Both lines idle released; scl stands high between frames.
	initial
	begin
		scl = 1'b1;
		sda_oe_n = 1'b1;
	end
	// Four cycles per phase keeps each scl phase above the two-cycle floor.
	task automatic half();
		repeat (4) @(negedge clk);
	endtask
	// Also serves as repeated start, since it releases sda while scl is low.
	task automatic start();
		sda_oe_n = 1'b1;
		half();
		scl = 1'b1;
		half();
		sda_oe_n = 1'b0;
		half();
		scl = 1'b0;
		@(negedge clk);
	endtask
	task automatic stop();
		sda_oe_n = 1'b0;
		half();
		scl = 1'b1;
		half();
		sda_oe_n = 1'b1;
		half();
	endtask
	// Sda is sampled late in the high phase, after the target has settled it.
	task automatic bit_io(input logic b, output logic s);
		sda_oe_n = b;
		half();
		scl = 1'b1;
		half();
		s = sda;
		scl = 1'b0;
		@(negedge clk);
	endtask
	task automatic xfer(input logic [7:0] d, input logic ack_n, output logic [7:0] q,
		output logic nak);
		for (int i = 7; i >= 0; i--)
			bit_io(d[i], q[i]);
		bit_io(ack_n, nak);
	endtask
	// ------------------------------------------------------------
	// Single-byte register accesses by index.
	// ------------------------------------------------------------
	task automatic write_reg(input logic [6:0] a, input logic [7:0] idx, input logic [7:0] d,
		output logic nak);
		logic [7:0] q;
		logic [2:0] n;
		start();
		xfer({a, 1'b0}, 1'b1, q, n[0]);
		xfer(idx, 1'b1, q, n[1]);
		xfer(d, 1'b1, q, n[2]);
		stop();
		nak = |n;
	endtask
	task automatic read_reg(input logic [6:0] a, input logic [7:0] idx, output logic [7:0] q,
		output logic nak);
		logic [7:0] z;
		logic [3:0] n;
		start();
		xfer({a, 1'b0}, 1'b1, z, n[0]);
		xfer(idx, 1'b1, z, n[1]);
		start();
		xfer({a, 1'b1}, 1'b1, z, n[2]);
		xfer(8'hff, 1'b1, q, n[3]);
		stop();
		nak = |n[2:0];
	endtask
endmodule // crc_i2c_host
`default_nettype wire

/* verif/test_charge_regulation_config_regs.sv */
// Self-checking bench for the charge regulation configuration bank.
// Assumes the host model drives scl and its half of the open-drain sda.
`default_nettype none
module test_charge_regulation_config_regs;
	import crc_pkg::*;
	timeunit 1ns;
	timeprecision 1ps;
	// ------------------------------------------------------------
	// Signals and instances.
	// ------------------------------------------------------------
	localparam logic [6:0] ADDR = CRC_DEV_ADDR_DEFAULT;
	logic       clk = 1'b0;
	logic       rstn = 1'b0;
	logic       scl, host_oe_n, sda_out, sda_oe_n, sda, wd_exp, nak;
	wire logic [7:0] cv_o, tt_o, ct_o;
	logic [7:0] rd;
	int         failures = 0;
	int         check_count = 0;
	always #4 clk = ~clk;
	// Pull-up: the wire is low only while some party pulls it down.
	assign sda = ~((~sda_oe_n & ~sda_out) | ~host_oe_n);
	crc_i2c_host host_u (.clk(clk), .sda(sda), .scl(scl), .sda_oe_n(host_oe_n));
	crc_config_regs #(.DEV_ADDR(ADDR), .WDOG_BASE_CYCLES(36'd50)) dut_u (
		.clk(clk), .rstn(rstn), .scl_in(scl), .sda_in(sda), .sda_out(sda_out),
		.sda_oe_n(sda_oe_n), .charge_voltage_code(cv_o[7:2]),
		.precharge_exit_threshold_sel(cv_o[1]), .recharge_offset_sel(cv_o[0]),
		.term_enable(tt_o[7]), .term_early_ind(tt_o[6]), .watchdog_period_sel(tt_o[5:4]),
		.safety_timer_enable(tt_o[3]), .fast_charge_time_limit(tt_o[2:1]),
		.cold_current_ratio_sel(tt_o[0]), .ir_comp_resistance(ct_o[7:5]),
		.ir_comp_clamp(ct_o[4:2]), .die_temp_limit(ct_o[1:0]), .watchdog_expired(wd_exp));
	// ------------------------------------------------------------
	// Shared tasks.
	// ------------------------------------------------------------
	task automatic check(input string what, input logic [7:0] exp, input logic [7:0] got);
		check_count++;
		if (got !== exp)
		begin
			failures++;
			$display("mismatch %s expected %h seen %h", what, exp, got);
		end
	endtask
	task automatic print_verdict();
		$display("checks %0d failures %0d", check_count, failures);
		if (failures == 0 && check_count > 0)
			$display("STATUS OK");
		else
			$display("STATUS NOT OK");
		$finish;
	endtask
	task automatic do_reset();
		rstn = 1'b0;
		repeat (3) @(negedge clk);
		rstn = 1'b1;
		@(negedge clk);
	endtask
	task automatic wait_exp(input int n);
		for (int i = 0; i < n && wd_exp !== 1'b1; i++)
			@(negedge clk);
	endtask
	// ------------------------------------------------------------
	// Scenarios.
	// ------------------------------------------------------------
	task automatic test_defaults();
		check("cv_out", 8'hb2, cv_o);
		check("cv_code", 8'h2c, {2'b00, cv_o[7:2]});
		check("tt_out", 8'h9a, tt_o);
		check("ct_out", 8'h03, ct_o);
		check("expired", 8'h00, {7'h0, wd_exp});
		host_u.read_reg(ADDR, 8'h04, rd, nak);
		check("rd04", 8'hb2, rd);
		host_u.read_reg(ADDR, 8'h05, rd, nak);
		check("rd05", 8'h9a, rd);
		host_u.read_reg(ADDR, 8'h06, rd, nak);
		check("rd06", 8'h03, rd);
	endtask
	// Patterns reach every code of the 2-bit fields; e3 is the top charge voltage code.
	task automatic test_fields();
		logic [7:0] pat [5] = '{8'h00, 8'h55, 8'haa, 8'hff, 8'he3};
		for (int r = 4; r <= 6; r++)
			for (int p = 0; p < 5; p++)
			begin
				host_u.write_reg(ADDR, 8'(r), pat[p], nak);
				check("wr_ack", 8'h00, {7'h0, nak});
				check("fields", pat[p], r == 4 ? cv_o : r == 5 ? tt_o : ct_o);
				host_u.read_reg(ADDR, 8'(r), rd, nak);
				check("readback", pat[p], rd);
			end
	endtask
	task automatic test_unmapped();
		host_u.write_reg(ADDR ^ 7'h01, 8'h04, 8'h00, nak);
		check("addr_nak", 8'h01, {7'h0, nak});
		check("cv_keep", 8'he3, cv_o);
		host_u.write_reg(ADDR, 8'h07, 8'hff, nak);
		host_u.read_reg(ADDR, 8'h07, rd, nak);
		check("rd07", 8'h00, rd);
		check("ct_keep", 8'he3, ct_o);
	endtask
	// Two bytes in one frame walk the index upward, for writes and acknowledged reads.
	task automatic test_burst();
		logic [7:0] q;
		host_u.start();
		host_u.xfer({ADDR, 1'b0}, 1'b1, q, nak);
		host_u.xfer(8'h05, 1'b1, q, nak);
		host_u.xfer(8'h9a, 1'b1, q, nak);
		host_u.xfer(8'h03, 1'b1, q, nak);
		host_u.stop();
		check("burst_tt", 8'h9a, tt_o);
		check("burst_ct", 8'h03, ct_o);
		host_u.start();
		host_u.xfer({ADDR, 1'b0}, 1'b1, q, nak);
		host_u.xfer(8'h05, 1'b1, q, nak);
		host_u.start();
		host_u.xfer({ADDR, 1'b1}, 1'b1, q, nak);
		host_u.xfer(8'hff, 1'b0, q, nak);
		check("burst_rd1", 8'h9a, q);
		host_u.xfer(8'hff, 1'b1, q, nak);
		check("burst_rd2", 8'h03, q);
		host_u.stop();
	endtask
	// Base is 50 cycles; a kick ends about 25 cycles before its write returns.
	task automatic test_watchdog();
		host_u.write_reg(ADDR, 8'h05, 8'h9a, nak);
		host_u.write_reg(ADDR, 8'h01, 8'h40, nak);
		repeat (10) @(negedge clk);
		check("wd40_early", 8'h00, {7'h0, wd_exp});
		wait_exp(30);
		check("wd40_fire", 8'h01, {7'h0, wd_exp});
		host_u.read_reg(ADDR, 8'h01, rd, nak);
		check("kick_clear", 8'h00, rd);
		host_u.write_reg(ADDR, 8'h05, 8'h8a, nak);
		check("wd_off", 8'h00, {7'h0, wd_exp});
		host_u.write_reg(ADDR, 8'h05, 8'hba, nak);
		host_u.write_reg(ADDR, 8'h01, 8'h40, nak);
		check("kick_exp", 8'h00, {7'h0, wd_exp});
		repeat (160) @(negedge clk);
		check("wd160_early", 8'h00, {7'h0, wd_exp});
		wait_exp(40);
		check("wd160_fire", 8'h01, {7'h0, wd_exp});
	endtask
	// ------------------------------------------------------------
	// Main sequence and hang guard.
	// ------------------------------------------------------------
	initial
	begin
		do_reset();
		test_defaults();
		test_fields();
		test_unmapped();
		test_burst();
		test_watchdog();
		do_reset();
		test_defaults();
		print_verdict();
	end
	initial
	begin
		repeat (40000) @(posedge clk);
		failures++;
		print_verdict();
	end
endmodule // test_charge_regulation_config_regs
`default_nettype wire
